// *** pin_ctrl_defs.vh ***
// Purpose: constants for the port and bus pin state controller
// Assumes: 8-bit register port, index addressing
// Notes: port mode bit 1 means input
// Functional notes
// - after reset every port pin is an input; clock output enable is set the cycle after
// - port 0 direction selectable per bit
// - edge select registers pick interrupt edges
// - converter mode register governs converter trigger
// - realtime control register governs its trigger
// - port 1 six bits, five open-drain capable
// - port 2 pins 1, 2 open-drain capable
// - expansion mode turns port 4 into bus
// - address in first state, data after
// - muxed pins update every bus state
// - muxed pins float when bus inactive
// - port 3 address bits change in T1, held
// - internal program counter makes bus inactive
// - held lines undefined until first external access
// - clock output low when inhibited
// - hold waits for cycle end, then acknowledges
// - byte enables and bit 0 follow access size
`ifndef PIN_CTRL_DEFS_VH
`define PIN_CTRL_DEFS_VH
`define REG_P0_OUT   5'h00
`define REG_P0_DIR   5'h01
`define REG_P1_OUT   5'h02
`define REG_P1_DIR   5'h03
`define REG_P1_OD    5'h04
`define REG_P2_OUT   5'h05
`define REG_P2_DIR   5'h06
`define REG_P2_OD    5'h07
`define REG_P3_OUT   5'h08
`define REG_P3_DIR   5'h09
`define REG_P4_OUT   5'h0a
`define REG_P4_DIR   5'h0b
`define REG_MEM_MODE 5'h0c
`define REG_EDGE_R   5'h0d
`define REG_EDGE_F   5'h0e
`define REG_CONV     5'h0f
`define REG_REALTIME_PORT_CONTROL_REG     5'h10
`define REG_CLK_CTRL 5'h11
`define REG_STATUS   5'h12
`define DIR_RESET    8'hff
`define P1_OD_MASK   6'h37
`define P2_OD_MASK   8'h06
`define TRG_EN_BIT   0
`define TRG_RISE_BIT 1
`define TRG_FALL_BIT 2
`define CONV_PIN     5
`define RTP_PIN      6
`define SIZE_BYTE    2'h0
`define SIZE_HALF    2'h1
`define SIZE_WORD    2'h2
`define ST_IDLE      3'h0
`define ST_T1        3'h1
`define ST_T2        3'h2
`define ST_TW        3'h3
`define ST_T3        3'h4
`define ST_HOLD      3'h5
`endif

// *** edge_select.v ***
// Purpose: per-bit edge detection with rising and falling selects
// Assumes: inputs synchronous to clock
// Notes: one-cycle pulse per selected edge
`timescale 1ns/1ns
`default_nettype none
module edge_select (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire [7:0] pin_in,
	input  wire [7:0] rise_sel_in,
	input  wire [7:0] fall_sel_in,
	output reg  [7:0] pulse_out
);
	reg [7:0] prev;
	always @(posedge clk_in) begin
		if (rst_in) begin
			prev <= 8'h00;
			pulse_out <= 8'h00;
		end else begin
			prev <= pin_in;
			pulse_out <= (pin_in & ~prev & rise_sel_in) |
				(~pin_in & prev & fall_sel_in);
		end
	end
endmodule
`default_nettype wire

// *** bus_cycle_seq.v ***
// Purpose: external bus cycle state sequence with hold
// Assumes: go_in false while bus may not run
// Notes: states T1, T2, TW, T3, hold
`timescale 1ns/1ns
`default_nettype none
`include "pin_ctrl_defs.vh"
module bus_cycle_seq (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       go_in,
	input  wire       req_in,
	input  wire       wait_in,
	input  wire       hold_req_in,
	output reg  [2:0] state_out,
	output wire       accept_out
);
	reg [2:0] next_state;
	assign accept_out = (state_out == `ST_IDLE) && go_in &&
		req_in && !hold_req_in;
	always @* begin
		next_state = state_out;
		case (state_out)
		`ST_IDLE: begin
			if (hold_req_in)
				next_state = `ST_HOLD;
			else if (accept_out)
				next_state = `ST_T1;
		end
		`ST_T1: next_state = `ST_T2;
		`ST_T2: next_state = wait_in ? `ST_TW : `ST_T3;
		`ST_TW: next_state = wait_in ? `ST_TW : `ST_T3;
		`ST_T3: begin
			if (hold_req_in)
				next_state = `ST_HOLD;
			else
				next_state = `ST_IDLE;
		end
		`ST_HOLD: begin
			if (!hold_req_in)
				next_state = `ST_IDLE;
		end
		default: next_state = `ST_IDLE;
		endcase
	end
	always @(posedge clk_in) begin
		if (rst_in)
			state_out <= `ST_IDLE;
		else
			state_out <= next_state;
	end
endmodule
`default_nettype wire

// *** pin_state_ctrl.v ***
// Purpose: port pins, alternate functions and bus pin states
// Assumes: CPU side signals synchronous to CLOCK_IN
// Notes: every pin output and enable is registered
`timescale 1ns/1ns
`default_nettype none
`include "pin_ctrl_defs.vh"
module pin_state_ctrl (
	input  wire        CLOCK_IN,
	input  wire        RESET_IN,
	input  wire [4:0]  REG_ADDR_IN,
	input  wire [7:0]  REG_WDATA_IN,
	input  wire        REG_WRITE_IN,
	input  wire        REG_READ_IN,
	output reg  [7:0]  REG_RDATA_OUT,
	input  wire        HALT_IN,
	input  wire        IDLE_STOP_IN,
	input  wire        PC_INTERNAL_IN,
	input  wire        BUS_REQ_IN,
	input  wire [21:0] BUS_ADDR_IN,
	input  wire        BUS_WRITE_IN,
	input  wire [1:0]  BUS_SIZE_IN,
	input  wire [15:0] BUS_WDATA_IN,
	output reg         BUS_ACCEPT_OUT,
	output reg         BUS_DONE_OUT,
	output reg  [15:0] BUS_RDATA_OUT,
	input  wire        WAIT_IN,
	input  wire        HOLD_REQUEST_N_IN,
	output reg         HOLD_ACKNOWLEDGE_N_OUT,
	output reg         HOLD_ACKNOWLEDGE_OE_OUT,
	input  wire [7:0]  P0_IN,
	output reg  [7:0]  P0_OUT,
	output reg  [7:0]  P0_OE_OUT,
	input  wire [5:0]  P1_IN,
	output reg  [5:0]  P1_OUT,
	output reg  [5:0]  P1_OE_OUT,
	input  wire [7:0]  P2_IN,
	output reg  [7:0]  P2_OUT,
	output reg  [7:0]  P2_OE_OUT,
	input  wire [7:0]  P3_IN,
	output reg  [7:0]  P3_OUT,
	output reg  [7:0]  P3_OE_OUT,
	input  wire [7:0]  P4_IN,
	output reg  [7:0]  P4_OUT,
	output reg  [7:0]  P4_OE_OUT,
	input  wire [7:0]  MUXED_HI_IN,
	output reg  [7:0]  MUXED_HI_OUT,
	output reg         MUXED_HI_OE_OUT,
	output reg  [5:0]  UPPER_ADDRESS_LINES_OUT,
	output reg         HIGH_BYTE_ENABLE_N_OUT,
	output reg         LOW_BYTE_ENABLE_N_OUT,
	output reg         UPPER_OE_OUT,
	output reg         READ_WRITE_OUT,
	output reg         DATA_STROBE_N_OUT,
	output reg         LOW_BYTE_WRITE_STROBE_N_OUT,
	output reg         HIGH_BYTE_WRITE_STROBE_N_OUT,
	output reg         READ_STROBE_N_OUT,
	output reg         ADDRESS_LATCH_STROBE_N_OUT,
	output reg         CONTROL_OE_OUT,
	output reg         CLOCK_OUTPUT_PIN_OUT,
	output reg         CLOCK_OUTPUT_OE_OUT,
	output reg  [7:0]  IRQ_EDGE_OUT,
	output reg         CONVERTER_TRIGGER_OUT,
	output reg         REALTIME_PORT_TRIGGER_OUT
);
	// software registers
	reg [7:0] p0_out;
	reg [7:0] port0_direction_reg;
	reg [5:0] p1_out;
	reg [5:0] p1_dir;
	reg [5:0] p1_od;
	reg [7:0] p2_out;
	reg [7:0] p2_dir;
	reg [7:0] p2_od;
	reg [7:0] p3_out;
	reg [7:0] p3_dir;
	reg [7:0] p4_out;
	reg [7:0] port4_direction_reg;
	reg       memory_expansion_mode_reg;
	reg [7:0] rising_edge_select_reg;
	reg [7:0] falling_edge_select_reg;
	reg [2:0] converter_mode_reg;
	reg [2:0] realtime_port_control_reg;
	reg       clk_inhibit;
	// latched access
	reg [21:0] acc_addr;
	reg        acc_write;
	reg [1:0]  acc_size;
	reg [15:0] acc_wdata;
	reg        ext_accessed;
	reg        clk_div;
	// derived signals
	wire       ext = memory_expansion_mode_reg;
	wire       hold_req = ext && !HOLD_REQUEST_N_IN && !IDLE_STOP_IN;
	wire       bus_go = ext && !PC_INTERNAL_IN && !HALT_IN &&
		!IDLE_STOP_IN;
	wire [2:0] state;
	wire       accept;
	wire       in_hold = (state == `ST_HOLD);
	wire       in_t1 = (state == `ST_T1);
	wire       in_data = (state == `ST_T2) || (state == `ST_TW) ||
		(state == `ST_T3);
	wire       in_strobe = (state == `ST_T2) || (state == `ST_TW);
	wire [7:0] irq_pulse;
	wire [7:0] trg_pulse;
	wire       ube_n;
	wire       lbe_n;
	wire [15:0] ad_addr;
	wire [7:0] p1_oe_full;
	wire [7:0] p3_oe_full;

	// pin enable from direction (1 = input) and open-drain select
	function [7:0] port_oe;
		input [7:0] dir;
		input [7:0] out;
		input [7:0] od;
		begin
			port_oe = ~dir & ~(od & out);
		end
	endfunction

	bus_cycle_seq u_seq (
		.clk_in      (CLOCK_IN),
		.rst_in      (RESET_IN),
		.go_in       (bus_go),
		.req_in      (BUS_REQ_IN),
		.wait_in     (WAIT_IN),
		.hold_req_in (hold_req),
		.state_out   (state),
		.accept_out  (accept)
	);

	edge_select u_irq (
		.clk_in      (CLOCK_IN),
		.rst_in      (RESET_IN),
		.pin_in      (P0_IN),
		.rise_sel_in (rising_edge_select_reg),
		.fall_sel_in (falling_edge_select_reg),
		.pulse_out   (irq_pulse)
	);

	edge_select u_trg (
		.clk_in      (CLOCK_IN),
		.rst_in      (RESET_IN),
		.pin_in      (P0_IN),
		.rise_sel_in ({1'b0,
			realtime_port_control_reg[`TRG_RISE_BIT],
			converter_mode_reg[`TRG_RISE_BIT], 5'h00}),
		.fall_sel_in ({1'b0,
			realtime_port_control_reg[`TRG_FALL_BIT],
			converter_mode_reg[`TRG_FALL_BIT], 5'h00}),
		.pulse_out   (trg_pulse)
	);

	// byte enables, active low, and address bit 0
	assign ube_n = (acc_size == `SIZE_BYTE) && !acc_addr[0];
	assign lbe_n = (acc_size == `SIZE_BYTE) && acc_addr[0];
	assign ad_addr = {acc_addr[15:1],
		(acc_size == `SIZE_BYTE) & acc_addr[0]};
	assign p1_oe_full = port_oe({2'h3, p1_dir}, {2'h0, p1_out},
		{2'h0, p1_od});
	assign p3_oe_full = port_oe(p3_dir, p3_out, 8'h00);

	// register writes
	always @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			p0_out <= 8'h00;
			port0_direction_reg <= `DIR_RESET;
			p1_out <= 6'h00;
			p1_dir <= 6'h3f;
			p1_od <= 6'h00;
			p2_out <= 8'h00;
			p2_dir <= `DIR_RESET;
			p2_od <= 8'h00;
			p3_out <= 8'h00;
			p3_dir <= `DIR_RESET;
			p4_out <= 8'h00;
			port4_direction_reg <= `DIR_RESET;
			memory_expansion_mode_reg <= 1'b0;
			rising_edge_select_reg <= 8'h00;
			falling_edge_select_reg <= 8'h00;
			converter_mode_reg <= 3'h0;
			realtime_port_control_reg <= 3'h0;
			clk_inhibit <= 1'b0;
		end else if (REG_WRITE_IN) begin
			case (REG_ADDR_IN)
			`REG_P0_OUT: p0_out <= REG_WDATA_IN;
			`REG_P0_DIR: port0_direction_reg <= REG_WDATA_IN;
			`REG_P1_OUT: p1_out <= REG_WDATA_IN[5:0];
			`REG_P1_DIR: p1_dir <= REG_WDATA_IN[5:0];
			`REG_P1_OD: p1_od <= REG_WDATA_IN[5:0] &
				`P1_OD_MASK;
			`REG_P2_OUT: p2_out <= REG_WDATA_IN;
			`REG_P2_DIR: p2_dir <= REG_WDATA_IN;
			`REG_P2_OD: p2_od <= REG_WDATA_IN & `P2_OD_MASK;
			`REG_P3_OUT: p3_out <= REG_WDATA_IN;
			`REG_P3_DIR: p3_dir <= REG_WDATA_IN;
			`REG_P4_OUT: p4_out <= REG_WDATA_IN;
			`REG_P4_DIR: port4_direction_reg <= REG_WDATA_IN;
			`REG_MEM_MODE: memory_expansion_mode_reg <= REG_WDATA_IN[0];
			`REG_EDGE_R: rising_edge_select_reg <= REG_WDATA_IN;
			`REG_EDGE_F: falling_edge_select_reg <= REG_WDATA_IN;
			`REG_CONV: converter_mode_reg <= REG_WDATA_IN[2:0];
			`REG_REALTIME_PORT_CONTROL_REG: realtime_port_control_reg <= REG_WDATA_IN[2:0];
			`REG_CLK_CTRL: clk_inhibit <= REG_WDATA_IN[0];
			default: ;
			endcase
		end
	end

	// register reads: data registers return pin levels
	always @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			REG_RDATA_OUT <= 8'h00;
		end else if (REG_READ_IN) begin
			case (REG_ADDR_IN)
			`REG_P0_OUT: REG_RDATA_OUT <= P0_IN;
			`REG_P0_DIR: REG_RDATA_OUT <= port0_direction_reg;
			`REG_P1_OUT: REG_RDATA_OUT <= {2'h0, P1_IN};
			`REG_P1_DIR: REG_RDATA_OUT <= {2'h0, p1_dir};
			`REG_P1_OD: REG_RDATA_OUT <= {2'h0, p1_od};
			`REG_P2_OUT: REG_RDATA_OUT <= P2_IN;
			`REG_P2_DIR: REG_RDATA_OUT <= p2_dir;
			`REG_P2_OD: REG_RDATA_OUT <= p2_od;
			`REG_P3_OUT: REG_RDATA_OUT <= P3_IN;
			`REG_P3_DIR: REG_RDATA_OUT <= p3_dir;
			`REG_P4_OUT: REG_RDATA_OUT <= P4_IN;
			`REG_P4_DIR: REG_RDATA_OUT <= port4_direction_reg;
			`REG_MEM_MODE: REG_RDATA_OUT <= {7'h00, ext};
			`REG_EDGE_R: REG_RDATA_OUT <= rising_edge_select_reg;
			`REG_EDGE_F: REG_RDATA_OUT <= falling_edge_select_reg;
			`REG_CONV: REG_RDATA_OUT <= {5'h00, converter_mode_reg};
			`REG_REALTIME_PORT_CONTROL_REG: REG_RDATA_OUT <=
				{5'h00, realtime_port_control_reg};
			`REG_CLK_CTRL: REG_RDATA_OUT <= {7'h00, clk_inhibit};
			`REG_STATUS: REG_RDATA_OUT <= {2'h0, state, ext_accessed,
				in_hold, state != `ST_IDLE};
			default: REG_RDATA_OUT <= 8'h00;
			endcase
		end else begin
			REG_RDATA_OUT <= 8'h00;
		end
	end

	// access latch and CPU side answers
	always @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			acc_addr <= 22'h000000;
			acc_write <= 1'b0;
			acc_size <= `SIZE_WORD;
			acc_wdata <= 16'h0000;
			ext_accessed <= 1'b0;
			BUS_ACCEPT_OUT <= 1'b0;
			BUS_DONE_OUT <= 1'b0;
			BUS_RDATA_OUT <= 16'h0000;
		end else begin
			BUS_ACCEPT_OUT <= accept;
			BUS_DONE_OUT <= (state == `ST_T3);
			if (accept) begin
				acc_addr <= BUS_ADDR_IN;
				acc_write <= BUS_WRITE_IN;
				acc_size <= BUS_SIZE_IN;
				acc_wdata <= BUS_WDATA_IN;
			end
			if (!ext)
				ext_accessed <= 1'b0;
			else if (in_t1)
				ext_accessed <= 1'b1;
			if (state == `ST_T3 && !acc_write)
				BUS_RDATA_OUT <= {MUXED_HI_IN, P4_IN};
		end
	end

	// port pins and their bus alternates
	always @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			P0_OUT <= 8'h00;
			P0_OE_OUT <= 8'h00;
			P1_OUT <= 6'h00;
			P1_OE_OUT <= 6'h00;
			P2_OUT <= 8'h00;
			P2_OE_OUT <= 8'h00;
			P3_OUT <= 8'h00;
			P3_OE_OUT <= 8'h00;
			P4_OUT <= 8'h00;
			P4_OE_OUT <= 8'h00;
			MUXED_HI_OUT <= 8'h00;
			MUXED_HI_OE_OUT <= 1'b0;
		end else begin
			P0_OUT <= p0_out;
			P0_OE_OUT <= port_oe(port0_direction_reg, p0_out,
				8'h00);
			P1_OUT <= p1_out;
			P1_OE_OUT <= p1_oe_full[5:0];
			P2_OUT <= p2_out;
			P2_OE_OUT <= port_oe(p2_dir, p2_out, p2_od);
			if (ext) begin
				// mid address lines change only in T1
				if (in_t1)
					P3_OUT <= {acc_addr[15:13],
						p3_out[4:0]};
				else
					P3_OUT <= {P3_OUT[7:5], p3_out[4:0]};
				P3_OE_OUT <= {3'h7, p3_oe_full[4:0]};
				if (in_t1) begin
					P4_OUT <= ad_addr[7:0];
					MUXED_HI_OUT <= ad_addr[15:8];
				end else begin
					P4_OUT <= acc_wdata[7:0];
					MUXED_HI_OUT <= acc_wdata[15:8];
				end
				P4_OE_OUT <= {8{in_t1 ||
					(in_data && acc_write)}};
				MUXED_HI_OE_OUT <= in_t1 ||
					(in_data && acc_write);
			end else begin
				P3_OUT <= p3_out;
				P3_OE_OUT <= p3_oe_full;
				P4_OUT <= p4_out;
				P4_OE_OUT <= port_oe(port4_direction_reg, p4_out,
					8'h00);
				MUXED_HI_OUT <= 8'h00;
				MUXED_HI_OE_OUT <= 1'b0;
			end
		end
	end

	// upper address, byte enables, control strobes, hold
	always @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			UPPER_ADDRESS_LINES_OUT <= 6'h00;
			HIGH_BYTE_ENABLE_N_OUT <= 1'b1;
			LOW_BYTE_ENABLE_N_OUT <= 1'b1;
			UPPER_OE_OUT <= 1'b0;
			READ_WRITE_OUT <= 1'b1;
			DATA_STROBE_N_OUT <= 1'b1;
			LOW_BYTE_WRITE_STROBE_N_OUT <= 1'b1;
			HIGH_BYTE_WRITE_STROBE_N_OUT <= 1'b1;
			READ_STROBE_N_OUT <= 1'b1;
			ADDRESS_LATCH_STROBE_N_OUT <= 1'b1;
			CONTROL_OE_OUT <= 1'b0;
			HOLD_ACKNOWLEDGE_N_OUT <= 1'b1;
			HOLD_ACKNOWLEDGE_OE_OUT <= 1'b0;
		end else begin
			if (in_t1) begin
				UPPER_ADDRESS_LINES_OUT <= acc_addr[21:16];
				HIGH_BYTE_ENABLE_N_OUT <= ube_n;
				LOW_BYTE_ENABLE_N_OUT <= lbe_n;
			end
			UPPER_OE_OUT <= ext && !IDLE_STOP_IN &&
				!in_hold;
			READ_WRITE_OUT <= (in_t1 || in_data) ?
				!acc_write : 1'b1;
			DATA_STROBE_N_OUT <= !in_strobe;
			READ_STROBE_N_OUT <= !(in_strobe && !acc_write);
			LOW_BYTE_WRITE_STROBE_N_OUT <= !(in_strobe && acc_write &&
				!lbe_n);
			HIGH_BYTE_WRITE_STROBE_N_OUT <= !(in_strobe && acc_write &&
				!ube_n);
			ADDRESS_LATCH_STROBE_N_OUT <= !in_strobe;
			CONTROL_OE_OUT <= ext && !IDLE_STOP_IN &&
				!in_hold;
			HOLD_ACKNOWLEDGE_N_OUT <= !in_hold;
			HOLD_ACKNOWLEDGE_OE_OUT <= ext && !IDLE_STOP_IN;
		end
	end

	// clock output, edge pulses
	always @(posedge CLOCK_IN) begin
		if (RESET_IN) begin
			clk_div <= 1'b0;
			CLOCK_OUTPUT_PIN_OUT <= 1'b0;
			CLOCK_OUTPUT_OE_OUT <= 1'b0;
			IRQ_EDGE_OUT <= 8'h00;
			CONVERTER_TRIGGER_OUT <= 1'b0;
			REALTIME_PORT_TRIGGER_OUT <= 1'b0;
		end else begin
			clk_div <= !clk_div;
			CLOCK_OUTPUT_PIN_OUT <= clk_div && !clk_inhibit &&
				!IDLE_STOP_IN;
			CLOCK_OUTPUT_OE_OUT <= 1'b1;
			IRQ_EDGE_OUT <= irq_pulse;
			CONVERTER_TRIGGER_OUT <= trg_pulse[`CONV_PIN] &&
				converter_mode_reg[`TRG_EN_BIT];
			REALTIME_PORT_TRIGGER_OUT <= trg_pulse[`RTP_PIN] &&
				realtime_port_control_reg[`TRG_EN_BIT];
		end
	end
endmodule
`default_nettype wire

// *** pin_state_checker.sv ***
// Purpose: port assertions for pin_state_ctrl
// Assumes: pins lag the bus state by one cycle
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module pin_state_checker (
	input wire logic       CLOCK_IN,
	input wire logic       RESET_IN,
	input wire logic       REG_READ_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic       BUS_ACCEPT_OUT,
	input wire logic       BUS_DONE_OUT,
	input wire logic       HOLD_ACKNOWLEDGE_N_OUT,
	input wire logic [7:0] P0_OE_OUT,
	input wire logic [7:0] P4_OUT,
	input wire logic [7:0] P4_OE_OUT,
	input wire logic       MUXED_HI_OE_OUT,
	input wire logic [5:0] UPPER_ADDRESS_LINES_OUT,
	input wire logic       HIGH_BYTE_ENABLE_N_OUT,
	input wire logic       LOW_BYTE_ENABLE_N_OUT,
	input wire logic       UPPER_OE_OUT,
	input wire logic       READ_WRITE_OUT,
	input wire logic       DATA_STROBE_N_OUT,
	input wire logic       LOW_BYTE_WRITE_STROBE_N_OUT,
	input wire logic       READ_STROBE_N_OUT,
	input wire logic       ADDRESS_LATCH_STROBE_N_OUT,
	input wire logic       CONTROL_OE_OUT
);
	default clocking dc @(posedge CLOCK_IN);
	endclocking
	default disable iff (RESET_IN);

	a_reset_float: assert property ($past(RESET_IN) |->
		!CONTROL_OE_OUT && !UPPER_OE_OUT && !MUXED_HI_OE_OUT &&
		P0_OE_OUT == 8'h00 && P4_OE_OUT == 8'h00)
		else $error("bus pins driven right after reset");
	a_done_after_accept: assert property (BUS_ACCEPT_OUT |=>
		!BUS_DONE_OUT [*2] ##[1:40] BUS_DONE_OUT)
		else $error("bus cycle did not finish in time");
	a_hold_float: assert property (!HOLD_ACKNOWLEDGE_N_OUT |->
		!CONTROL_OE_OUT && !UPPER_OE_OUT && !MUXED_HI_OE_OUT)
		else $error("bus driven while hold acknowledged");
	a_strobe_after_t1: assert property ($fell(DATA_STROBE_N_OUT) |->
		$past(BUS_ACCEPT_OUT, 2) && !ADDRESS_LATCH_STROBE_N_OUT)
		else $error("data strobe not two cycles after accept");
	a_enables_match: assert property ($fell(ADDRESS_LATCH_STROBE_N_OUT) |->
		!(HIGH_BYTE_ENABLE_N_OUT && LOW_BYTE_ENABLE_N_OUT) &&
		LOW_BYTE_ENABLE_N_OUT == $past(P4_OUT[0]))
		else $error("byte enables disagree with address bit 0");
	a_read_status: assert property (CONTROL_OE_OUT && !READ_STROBE_N_OUT |->
		READ_WRITE_OUT && LOW_BYTE_WRITE_STROBE_N_OUT)
		else $error("read strobe with write status");
	a_write_status: assert property (CONTROL_OE_OUT &&
		!LOW_BYTE_WRITE_STROBE_N_OUT |-> !READ_WRITE_OUT && READ_STROBE_N_OUT)
		else $error("write strobe with read status");
	a_mux_release: assert property (BUS_DONE_OUT |=> !MUXED_HI_OE_OUT)
		else $error("address data lines driven after cycle end");
	a_upper_held: assert property (!$past(BUS_ACCEPT_OUT) &&
		!$past(RESET_IN) |-> $stable(UPPER_ADDRESS_LINES_OUT))
		else $error("upper address changed outside first state");
	a_rdata_quiet: assert property (!$past(REG_READ_IN) |->
		REG_RDATA_OUT == 8'h00)
		else $error("read data without read strobe");

	c_read_done: cover property (BUS_DONE_OUT && READ_WRITE_OUT);
	c_write: cover property ($fell(LOW_BYTE_WRITE_STROBE_N_OUT));
	c_hold: cover property (!HOLD_ACKNOWLEDGE_N_OUT);
endmodule

bind pin_state_ctrl pin_state_checker i_pin_state_checker (.CLOCK_IN,
	.RESET_IN, .REG_READ_IN, .REG_RDATA_OUT, .BUS_ACCEPT_OUT, .BUS_DONE_OUT,
	.HOLD_ACKNOWLEDGE_N_OUT, .P0_OE_OUT, .P4_OUT, .P4_OE_OUT,
	.MUXED_HI_OE_OUT, .UPPER_ADDRESS_LINES_OUT, .HIGH_BYTE_ENABLE_N_OUT,
	.LOW_BYTE_ENABLE_N_OUT, .UPPER_OE_OUT, .READ_WRITE_OUT, .DATA_STROBE_N_OUT,
	.LOW_BYTE_WRITE_STROBE_N_OUT, .READ_STROBE_N_OUT,
	.ADDRESS_LATCH_STROBE_N_OUT, .CONTROL_OE_OUT);
`default_nettype wire

// *** ext_mem_model.sv ***
// Purpose: external memory on the muxed expansion bus
// Assumes: pins sampled on the rising clock edge
// Notes: released data lines toggle every cycle
`timescale 1ns/1ns
`default_nettype none
module ext_mem_model (
	input  wire logic       clk_in,
	input  wire logic       slow_in,
	input  wire logic [7:0] ad_lo_in,
	input  wire logic [7:0] ad_hi_in,
	input  wire logic       address_latch_strobe_n_in,
	input  wire logic       data_strobe_n_in,
	input  wire logic       rd_n_in,
	input  wire logic       wrl_n_in,
	input  wire logic       wrh_n_in,
	output logic      [7:0] ad_lo_out,
	output logic      [7:0] ad_hi_out,
	output logic            wait_out
);
	logic [15:0] mem [0:15];
	logic [15:0] last_ad = 16'h0000;
	logic [15:0] addr = 16'h0000;
	logic [15:0] rel = 16'h0000;
	logic        address_latch_strobe_d = 1'b1;
	logic [1:0]  wcnt = 2'h0;
	// address is what the lines carried just before the strobe fell
	wire  [15:0] cur = (address_latch_strobe_d && !address_latch_strobe_n_in) ? last_ad : addr;

	always @(posedge clk_in) begin
		address_latch_strobe_d <= address_latch_strobe_n_in;
		last_ad <= {ad_hi_in, ad_lo_in};
		addr <= cur;
		rel <= ~rel;
		if (data_strobe_n_in)
			wcnt <= 2'h0;
		else if (wcnt != 2'h2)
			wcnt <= wcnt + 2'h1;
		if (!wrl_n_in)
			mem[cur[4:1]][7:0] <= ad_lo_in;
		if (!wrh_n_in)
			mem[cur[4:1]][15:8] <= ad_hi_in;
	end

	assign ad_lo_out = rd_n_in ? rel[7:0] : mem[cur[4:1]][7:0];
	assign ad_hi_out = rd_n_in ? rel[15:8] : mem[cur[4:1]][15:8];
	// slow answer: three wait states per cycle
	assign wait_out = slow_in && wcnt != 2'h2;
endmodule
`default_nettype wire

// *** pin_state_ctrl_tb.sv ***
// Purpose: self-checking bench for pin_state_ctrl
// Assumes: ext_mem_model sits on the expansion bus
// Notes: register cases in a table, bus and mode cases after it
`timescale 1ns/1ns
`default_nettype none
`include "pin_ctrl_defs.vh"
module pin_state_ctrl_tb;
	logic        CLOCK_IN = 1'b0;
	logic        RESET_IN = 1'b1;
	logic [4:0]  REG_ADDR_IN = 5'h00;
	logic [7:0]  REG_WDATA_IN = 8'h00;
	logic        REG_WRITE_IN = 1'b0, REG_READ_IN = 1'b0;
	logic        HALT_IN = 1'b0, IDLE_STOP_IN = 1'b0, PC_INTERNAL_IN = 1'b0;
	logic        BUS_REQ_IN = 1'b0, BUS_WRITE_IN = 1'b0, slow = 1'b0;
	logic [21:0] BUS_ADDR_IN = 22'h000000;
	logic [1:0]  BUS_SIZE_IN = 2'h0;
	logic [15:0] BUS_WDATA_IN = 16'h0000;
	logic        HOLD_REQUEST_N_IN = 1'b1;
	logic [7:0]  P0_IN = 8'h00, P2_IN = 8'h00, P3_IN = 8'h00;
	logic [5:0]  P1_IN = 6'h00;
	wire         WAIT_IN, BUS_ACCEPT_OUT, BUS_DONE_OUT, MUXED_HI_OE_OUT;
	wire  [7:0]  P4_IN, MUXED_HI_IN, ad_lo, ad_hi, REG_RDATA_OUT, IRQ_EDGE_OUT;
	wire  [7:0]  P0_OUT, P0_OE_OUT, P2_OUT, P2_OE_OUT, P3_OUT, P3_OE_OUT;
	wire  [7:0]  P4_OUT, P4_OE_OUT, MUXED_HI_OUT;
	wire  [5:0]  P1_OUT, P1_OE_OUT, UPPER_ADDRESS_LINES_OUT;
	wire  [15:0] BUS_RDATA_OUT;
	wire         HOLD_ACKNOWLEDGE_N_OUT, HOLD_ACKNOWLEDGE_OE_OUT, UPPER_OE_OUT;
	wire         HIGH_BYTE_ENABLE_N_OUT, LOW_BYTE_ENABLE_N_OUT, READ_WRITE_OUT;
	wire         DATA_STROBE_N_OUT, LOW_BYTE_WRITE_STROBE_N_OUT;
	wire         HIGH_BYTE_WRITE_STROBE_N_OUT, READ_STROBE_N_OUT;
	wire         ADDRESS_LATCH_STROBE_N_OUT, CONTROL_OE_OUT;
	wire         CLOCK_OUTPUT_PIN_OUT, CLOCK_OUTPUT_OE_OUT;
	wire         CONVERTER_TRIGGER_OUT, REALTIME_PORT_TRIGGER_OUT;
	int          err_total = 0, compares = 0, cycles = 0;
	int          irq_n = 0, conv_n = 0, rtp_n = 0, clk_n = 0, acc_n = 0;
	// address, write data, expected read data
	logic [20:0] rows [0:5] = '{
		{`REG_P0_DIR, 8'h6b, 8'h6b},
		{`REG_P1_DIR, 8'hff, 8'h3f},
		{`REG_EDGE_R, 8'h01, 8'h01},
		{`REG_CONV, 8'h03, 8'h03},
		{`REG_REALTIME_PORT_CONTROL_REG, 8'h05, 8'h05},
		{5'h1f, 8'hff, 8'h00}};

	assign P4_IN = (P4_OE_OUT & P4_OUT) | (~P4_OE_OUT & ad_lo);
	assign MUXED_HI_IN = MUXED_HI_OE_OUT ? MUXED_HI_OUT : ad_hi;

	ext_mem_model i_ext_mem_model (.clk_in(CLOCK_IN), .slow_in(slow),
		.ad_lo_in(P4_IN), .ad_hi_in(MUXED_HI_IN),
		.address_latch_strobe_n_in(ADDRESS_LATCH_STROBE_N_OUT), .data_strobe_n_in(DATA_STROBE_N_OUT),
		.rd_n_in(READ_STROBE_N_OUT), .wrl_n_in(LOW_BYTE_WRITE_STROBE_N_OUT),
		.wrh_n_in(HIGH_BYTE_WRITE_STROBE_N_OUT), .ad_lo_out(ad_lo),
		.ad_hi_out(ad_hi), .wait_out(WAIT_IN));
	pin_state_ctrl i_pin_state_ctrl (.*);

	always #2 CLOCK_IN = ~CLOCK_IN;

	always @(posedge CLOCK_IN) begin
		cycles++;
		irq_n += (IRQ_EDGE_OUT[0] === 1'b1);
		conv_n += (CONVERTER_TRIGGER_OUT === 1'b1);
		rtp_n += (REALTIME_PORT_TRIGGER_OUT === 1'b1);
		clk_n += (CLOCK_OUTPUT_PIN_OUT === 1'b1);
		acc_n += (BUS_ACCEPT_OUT === 1'b1);
		if (cycles == 3000) begin
			err_total++;
			close_out();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK_IN);
		#1;
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CLOCK_IN);
		REG_ADDR_IN <= a;
		REG_WDATA_IN <= d;
		REG_WRITE_IN <= 1'b1;
		@(posedge CLOCK_IN);
		REG_WRITE_IN <= 1'b0;
	endtask

	task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge CLOCK_IN);
		REG_ADDR_IN <= a;
		REG_READ_IN <= 1'b1;
		@(posedge CLOCK_IN);
		REG_READ_IN <= 1'b0;
		#1;
		d = REG_RDATA_OUT;
	endtask

	task automatic bus(input logic w, input logic [1:0] s,
		input logic [21:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge CLOCK_IN);
		BUS_REQ_IN <= 1'b1;
		BUS_WRITE_IN <= w;
		BUS_SIZE_IN <= s;
		BUS_ADDR_IN <= a;
		BUS_WDATA_IN <= d;
		do tick(1); while (BUS_ACCEPT_OUT !== 1'b1 && ++n < 20);
		@(posedge CLOCK_IN);
		BUS_REQ_IN <= 1'b0;
		while (BUS_DONE_OUT !== 1'b1 && ++n < 60)
			tick(1);
		chk("bus done", 1, n < 60);
	endtask

	task automatic idle_pins;
		chk("idle strobes", 5'h1f, {CONTROL_OE_OUT, READ_WRITE_OUT,
			DATA_STROBE_N_OUT, READ_STROBE_N_OUT, ADDRESS_LATCH_STROBE_N_OUT});
	endtask

	task automatic close_out;
		$display("mismatches %0d of %0d compares", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		logic [7:0] d;
		repeat (8) @(posedge CLOCK_IN);
		RESET_IN <= 1'b0;
		tick(1);
		chk("reset oe", 0, {P0_OE_OUT, P4_OE_OUT, CONTROL_OE_OUT});
		reg_rd(`REG_P4_DIR, d);
		chk("p4 dir", 8'hff, d);
		for (int i = 0; i < 6; i++) begin
			reg_wr(rows[i][20:16], rows[i][15:8]);
			reg_rd(rows[i][20:16], d);
			chk("reg read", rows[i][7:0], d);
		end
		tick(2);
		chk("p0 oe", 8'h94, P0_OE_OUT);
		@(posedge CLOCK_IN);
		P0_IN <= 8'h61;
		tick(6);
		@(posedge CLOCK_IN);
		P0_IN <= 8'h00;
		tick(6);
		chk("irq edges", 1, irq_n);
		chk("conv trig", 1, conv_n);
		chk("rtp trig", 1, rtp_n);
		reg_wr(`REG_P1_OUT, 8'h3f);
		reg_wr(`REG_P1_OD, 8'hff);
		reg_wr(`REG_P1_DIR, 8'h00);
		reg_wr(`REG_P2_OUT, 8'hff);
		reg_wr(`REG_P2_OD, 8'hff);
		reg_wr(`REG_P2_DIR, 8'h00);
		tick(2);
		chk("p1 od", 6'h08, P1_OE_OUT);
		chk("p2 od", 8'hf9, P2_OE_OUT);
		chk("port outs", {6'h3f, 8'hff}, {P1_OUT, P2_OUT});
		reg_wr(`REG_CLK_CTRL, 8'h01);
		tick(3);
		clk_n = 0;
		tick(8);
		chk("clock_output_pin off", 0, clk_n);
		reg_wr(`REG_CLK_CTRL, 8'h00);
		tick(3);
		clk_n = 0;
		tick(8);
		chk("clock_output_pin on", 4, clk_n);
		chk("clk oe", 1, CLOCK_OUTPUT_OE_OUT);
		reg_wr(`REG_MEM_MODE, 8'h01);
		tick(2);
		chk("ad float", 0, {MUXED_HI_OE_OUT, P4_OE_OUT});
		bus(1'b1, `SIZE_HALF, 22'h2ba006, 16'h1234);
		bus(1'b0, `SIZE_HALF, 22'h2ba006, 16'h0000);
		chk("read data", 16'h1234, BUS_RDATA_OUT);
		tick(2);
		chk("held addr", 9'h15d, {UPPER_ADDRESS_LINES_OUT, P3_OUT[7:5]});
		chk("p3 oe", 8'he0, P3_OE_OUT);
		@(posedge CLOCK_IN);
		slow <= 1'b1;
		bus(1'b0, `SIZE_HALF, 22'h2ba006, 16'h0000);
		chk("slow read", 16'h1234, BUS_RDATA_OUT);
		bus(1'b0, `SIZE_BYTE, 22'h2ba007, 16'h0000);
		chk("odd enables", 2'h1, {HIGH_BYTE_ENABLE_N_OUT,
			LOW_BYTE_ENABLE_N_OUT});
		@(posedge CLOCK_IN);
		PC_INTERNAL_IN <= 1'b1;
		BUS_REQ_IN <= 1'b1;
		tick(2);
		acc_n = 0;
		tick(10);
		chk("accepts", 0, acc_n);
		idle_pins();
		@(posedge CLOCK_IN);
		PC_INTERNAL_IN <= 1'b0;
		BUS_REQ_IN <= 1'b0;
		HALT_IN <= 1'b1;
		tick(3);
		idle_pins();
		@(posedge CLOCK_IN);
		HALT_IN <= 1'b0;
		IDLE_STOP_IN <= 1'b1;
		tick(3);
		chk("idle float", 0, {CONTROL_OE_OUT, UPPER_OE_OUT, MUXED_HI_OE_OUT,
			CLOCK_OUTPUT_PIN_OUT});
		@(posedge CLOCK_IN);
		IDLE_STOP_IN <= 1'b0;
		fork
			bus(1'b0, `SIZE_WORD, 22'h2ba006, 16'h0000);
			begin
				tick(2);
				@(posedge CLOCK_IN);
				HOLD_REQUEST_N_IN <= 1'b0;
			end
		join
		tick(4);
		chk("hold ack", 3'h2, {HOLD_ACKNOWLEDGE_N_OUT, HOLD_ACKNOWLEDGE_OE_OUT,
			CONTROL_OE_OUT});
		@(posedge CLOCK_IN);
		HOLD_REQUEST_N_IN <= 1'b1;
		tick(4);
		chk("hold done", 1, HOLD_ACKNOWLEDGE_N_OUT);
		@(posedge CLOCK_IN);
		RESET_IN <= 1'b1;
		tick(3);
		chk("reset pins", 0, {P4_OE_OUT, UPPER_OE_OUT, CONTROL_OE_OUT,
			HOLD_ACKNOWLEDGE_OE_OUT, CLOCK_OUTPUT_OE_OUT});
		@(posedge CLOCK_IN);
		RESET_IN <= 1'b0;
		tick(1);
		chk("rerun oe", 0, {P0_OE_OUT, P4_OE_OUT, CONTROL_OE_OUT});
		close_out();
	end
endmodule
`default_nettype wire
